// ### design/asr_state_file.sv
// Architectural register state: general registers, stack pointers,
// banked return state and processor state fields.
// Assumes a pipeline on clk driving the ports, APB master on clk.
//
// What this block does
// - Thirty-one 64-bit general registers, all tiers
// - Narrow view is the low word
// - Specifier 31 is normally the zero register
// - Allowed fields map specifier 31 to stack
// - Zero register reads zero, writes dropped
// - One stack pointer per tier, four total
// - Return address and saved state, tiers 1-3
// - Exception entry selects target tier stack
// - Selector picks tier-zero or own stack
// - Shared option everywhere, dedicated above zero
// - Arithmetic encodings may read/write stack pointer
// - Program counter never a named register
// - Entry stores return address in target bank
// - Entry copies processor state to saved state
// - Saved state holds flags, masks, mode fields
// - Width bit saves zero from 64-bit state
// - Higher banks hold while lower tier runs
// - Processor state fields as listed, two-bit tier
// - Return restores state, branches to return address, unless saved tier is higher
// - Tier zero reaches only the condition flags
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module asr_state_file #(
   parameter int AW = 12
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            nrst,
   // APB slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [AW-1:0]   paddr,
   input  wire logic [31:0]     pwdata,
   output var  logic [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   // Read port A
   input  wire logic [4:0]      rd_a_idx,
   input  wire logic            rd_a_wide,
   input  wire logic            rd_a_sp_ok,
   output var  logic [63:0]     rd_a_data,
   // Read port B
   input  wire logic [4:0]      rd_b_idx,
   input  wire logic            rd_b_wide,
   input  wire logic            rd_b_sp_ok,
   output var  logic [63:0]     rd_b_data,
   // Write port
   input  wire logic            wr_en,
   input  wire logic [4:0]      wr_idx,
   input  wire logic            wr_wide,
   input  wire logic            wr_sp_ok,
   input  wire logic [63:0]     wr_data,
   // Condition flags and other state field writes
   input  wire logic            flags_we,
   input  wire logic [3:0]      flags_in,
   input  wire logic            ps_we,
   input  wire logic [3:0]      ps_masks_in,
   input  wire logic            ps_sel_in,
   // Exception entry and return
   input  wire logic            exc_take,
   input  wire logic [1:0]      exc_target,
   input  wire logic [63:0]     exc_ret_addr,
   input  wire logic            return_from_handler_req,
   output var  logic            return_from_handler_valid,
   output var  logic [63:0]     return_from_handler_pc,
   output var  logic            undef_fault,
   // Processor state view
   output var  logic [1:0]      priv_tier,
   output var  logic            stack_sel,
   output var  logic [3:0]      cond_flags,
   output var  logic [3:0]      mask_bits,
   output var  logic            step_bit,
   output var  logic            bad_exec_state_flag,
   output var  logic            exec_width_sel,
   output logic [31:0]          proc_state
);

   // ==========================================================
   // Storage
   logic [63:0] wide_gp_regs [asr_pkg::NREG];
   logic [63:0] stack_ptr [4];
   logic [63:0] return_addr_reg [1:3];
   logic [31:0] saved_state_reg [1:3];
   logic [63:0] wr_val;
   logic        gp_we;
   logic        sp_we;
   logic [1:0]  sp_idx;
   logic        exc_ok;
   logic        return_from_handler_ok;
   logic [31:0] ret_word;
   logic [1:0]  ret_tier;

   // ==========================================================
   // Write data shaping
   always_comb begin
      if (wr_wide) begin
         wr_val = wr_data;
      end else begin
         wr_val = {{asr_pkg::HALF{1'b0}}, wr_data[31:0]};
      end
   end

   assign gp_we = wr_en && (wr_idx != asr_pkg::ZERO_IDX);
   assign sp_we = wr_en && (wr_idx == asr_pkg::ZERO_IDX)
                  && wr_sp_ok;

   // ==========================================================
   // General registers
   genvar gi;
   generate
      for (gi = 0; gi < asr_pkg::NREG; gi++) begin : g_gp
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               wide_gp_regs[gi] <= '0;
            end else if (gp_we && wr_idx == 5'(gi)) begin
               wide_gp_regs[gi] <= wr_val;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Stack pointer selection and banks
   always_comb begin
      if (priv_tier == asr_pkg::TIER0 || !stack_sel) begin
         sp_idx = asr_pkg::TIER0;
      end else begin
         sp_idx = priv_tier;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            stack_ptr[i] <= '0;
         end
      end else if (sp_we) begin
         stack_ptr[sp_idx] <= wr_val;
      end
   end

   // ==========================================================
   // Read ports, one cycle latency
   function automatic logic [63:0] rd_val(input logic [4:0] idx,
                                          input logic wide,
                                          input logic sp_ok);
      logic [63:0] v;
      v = '0;
      if (idx != asr_pkg::ZERO_IDX) begin
         v = wide_gp_regs[idx];
      end else if (sp_ok) begin
         v = stack_ptr[sp_idx];
      end
      if (!wide) begin
         v = {{asr_pkg::HALF{1'b0}}, v[31:0]};
      end
      return v;
   endfunction : rd_val

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_a_data <= '0;
         rd_b_data <= '0;
      end else begin
         rd_a_data <= rd_val(rd_a_idx, rd_a_wide, rd_a_sp_ok);
         rd_b_data <= rd_val(rd_b_idx, rd_b_wide, rd_b_sp_ok);
      end
   end

   // ==========================================================
   // Processor state word
   always_comb begin
      proc_state = '0;
      proc_state[asr_pkg::POS_FLAGS +: 4] = cond_flags;
      proc_state[asr_pkg::POS_SS]         = step_bit;
      proc_state[asr_pkg::POS_IL]         = bad_exec_state_flag;
      proc_state[asr_pkg::POS_MASKS +: 4] = mask_bits;
      proc_state[asr_pkg::POS_WIDTH]      = exec_width_sel;
      proc_state[asr_pkg::POS_TIER +: 2]  = priv_tier;
      proc_state[asr_pkg::POS_SPSEL]      = stack_sel;
   end

   assign exc_ok  = exc_take && (exc_target != asr_pkg::TIER0)
                    && (exc_target >= priv_tier);
   assign return_from_handler_ok = return_from_handler_req && !exc_ok
                    && (priv_tier != asr_pkg::TIER0);
   assign ret_word = (priv_tier == asr_pkg::TIER0) ? '0
                     : saved_state_reg[priv_tier];
   assign ret_tier = ret_word[asr_pkg::POS_TIER +: 2];

   // ==========================================================
   // Processor state update
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         priv_tier           <= asr_pkg::RST_TIER;
         stack_sel           <= 1'b1;
         cond_flags          <= asr_pkg::RST_FLAGS;
         mask_bits           <= asr_pkg::RST_MASKS;
         step_bit            <= 1'b0;
         bad_exec_state_flag <= 1'b0;
         exec_width_sel      <= asr_pkg::WIDTH_64;
      end else if (exc_ok) begin
         priv_tier           <= exc_target;
         stack_sel           <= 1'b1;
         mask_bits           <= asr_pkg::RST_MASKS;
         step_bit            <= 1'b0;
         bad_exec_state_flag <= 1'b0;
         exec_width_sel      <= asr_pkg::WIDTH_64;
      end else if (return_from_handler_ok && ret_tier > priv_tier) begin
         bad_exec_state_flag <= 1'b1;
      end else if (return_from_handler_ok) begin
         cond_flags     <= ret_word[asr_pkg::POS_FLAGS +: 4];
         mask_bits      <= ret_word[asr_pkg::POS_MASKS +: 4];
         step_bit       <= ret_word[asr_pkg::POS_SS];
         bad_exec_state_flag <= ret_word[asr_pkg::POS_IL];
         exec_width_sel <= ret_word[asr_pkg::POS_WIDTH];
         priv_tier      <= ret_tier;
         stack_sel      <= ret_word[asr_pkg::POS_SPSEL];
      end else begin
         if (flags_we) begin
            cond_flags <= flags_in;
         end
         if (ps_we && priv_tier != asr_pkg::TIER0) begin
            mask_bits <= ps_masks_in;
            stack_sel <= ps_sel_in;
         end
      end
   end

   // ==========================================================
   // Return branch and undefined access report
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         return_from_handler_valid  <= 1'b0;
         return_from_handler_pc     <= '0;
         undef_fault <= 1'b0;
      end else begin
         return_from_handler_valid  <= return_from_handler_ok && (ret_tier <= priv_tier);
         if (return_from_handler_ok) begin
            return_from_handler_pc <= return_addr_reg[priv_tier];
         end
         undef_fault <= !exc_ok && (priv_tier == asr_pkg::TIER0)
                        && (ps_we || return_from_handler_req);
      end
   end

   // ==========================================================
   // APB decode
   logic        apb_acc;
   logic        hit_ps;
   logic [1:0]  bank;
   logic        bank_hit;
   logic        bank_low;
   logic        apb_bank_we;

   always_comb begin
      bank     = asr_pkg::TIER0;
      bank_hit = 1'b0;
      hit_ps   = (paddr == AW'(asr_pkg::OFS_PS));
      if (paddr == AW'(asr_pkg::OFS_SS1)) begin
         bank     = asr_pkg::TIER1;
         bank_hit = 1'b1;
      end else if (paddr == AW'(asr_pkg::OFS_SS2)) begin
         bank     = asr_pkg::TIER2;
         bank_hit = 1'b1;
      end else if (paddr == AW'(asr_pkg::OFS_SS3)) begin
         bank     = asr_pkg::TIER3;
         bank_hit = 1'b1;
      end
   end

   assign apb_acc  = psel && penable;
   assign bank_low = bank_hit && (bank > priv_tier);
   assign pready   = apb_acc;
   assign pslverr  = apb_acc && ((!bank_hit && !hit_ps)
                     || (pwrite && (hit_ps || bank_low)));
   assign apb_bank_we = apb_acc && pwrite && bank_hit && !bank_low;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         if (bank_hit) begin
            prdata <= saved_state_reg[bank];
         end else if (hit_ps) begin
            prdata <= proc_state;
         end else begin
            prdata <= '0;
         end
      end
   end

   // ==========================================================
   // Banked return state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 1; i < 4; i++) begin
            saved_state_reg[i] <= '0;
            return_addr_reg[i] <= '0;
         end
      end else begin
         if (apb_bank_we && !(exc_ok && exc_target == bank)) begin
            saved_state_reg[bank] <= pwdata;
         end
         if (exc_ok) begin
            saved_state_reg[exc_target] <= proc_state;
            return_addr_reg[exc_target] <= exc_ret_addr;
         end
      end
   end

   // ==========================================================
   // Checks
   zero_read_a: assert property (@(posedge clk) disable iff (!nrst)
      (rd_a_idx == asr_pkg::ZERO_IDX && !rd_a_sp_ok)
      |=> rd_a_data == '0)
      else $error("zero register read not zero");

   narrow_read_a: assert property (@(posedge clk) disable iff (!nrst)
      !rd_a_wide |=> rd_a_data[63:32] == '0)
      else $error("narrow read upper half not zero");

   narrow_write_a: assert property (@(posedge clk) disable iff (!nrst)
      (wr_en && !wr_wide && wr_idx == 5'h00)
      |=> wide_gp_regs[0] == {32'h0, $past(wr_data[31:0])})
      else $error("narrow write did not clear upper bits");

   entry_stack_a: assert property (@(posedge clk) disable iff (!nrst)
      exc_ok |=> stack_sel && priv_tier == $past(exc_target))
      else $error("entry did not select target stack");

   entry_save_a: assert property (@(posedge clk) disable iff (!nrst)
      (exc_ok && exc_target == asr_pkg::TIER3)
      |=> saved_state_reg[3] == $past(proc_state)
          && return_addr_reg[3] == $past(exc_ret_addr))
      else $error("entry did not save state to bank");

   bank_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (priv_tier != asr_pkg::TIER3 && !exc_ok)
      |=> $stable(saved_state_reg[3]) && $stable(return_addr_reg[3]))
      else $error("higher bank changed at lower tier");

   return_from_handler_branch_a: assert property (@(posedge clk) disable iff (!nrst)
      (return_from_handler_ok && ret_tier <= priv_tier)
      |=> return_from_handler_valid && return_from_handler_pc == $past(return_addr_reg[priv_tier])
          && priv_tier == $past(ret_tier))
      else $error("return did not restore and branch");

   tier0_undef_a: assert property (@(posedge clk) disable iff (!nrst)
      (ps_we && !exc_take && priv_tier == asr_pkg::TIER0)
      |=> undef_fault && $stable(mask_bits))
      else $error("tier zero field write not refused");

   width_save_a: assert property (@(posedge clk) disable iff (!nrst)
      (exc_ok && exc_target == asr_pkg::TIER3 && !exec_width_sel)
      |=> !saved_state_reg[3][asr_pkg::POS_WIDTH])
      else $error("width bit not saved as zero");

endmodule : asr_state_file

`default_nettype wire

// ### design/asr_pkg.sv
// Constants for the architectural register state file.
// Assumes a single clock domain and APB register access.
package asr_pkg;

   // ==========================================================
   // Widths and register numbering
   localparam int          XLEN     = 64;
   localparam int          HALF     = 32;
   localparam int          NREG     = 31;
   localparam int          IDXW     = 5;
   localparam logic [4:0]  ZERO_IDX = 5'h1F;

   // ==========================================================
   // Privilege tiers
   localparam logic [1:0]  TIER0    = 2'h0;
   localparam logic [1:0]  TIER1    = 2'h1;
   localparam logic [1:0]  TIER2    = 2'h2;
   localparam logic [1:0]  TIER3    = 2'h3;

   // ==========================================================
   // APB register offsets
   localparam logic [11:0] OFS_SS1  = 12'h000;
   localparam logic [11:0] OFS_SS2  = 12'h004;
   localparam logic [11:0] OFS_SS3  = 12'h008;
   localparam logic [11:0] OFS_PS   = 12'h00C;

   // ==========================================================
   // Saved state word layout
   localparam int          POS_FLAGS = 28;
   localparam int          POS_SS    = 21;
   localparam int          POS_IL    = 20;
   localparam int          POS_MASKS = 6;
   localparam int          POS_WIDTH = 4;
   localparam int          POS_TIER  = 2;
   localparam int          POS_SPSEL = 0;

   // ==========================================================
   // Reset values
   localparam logic [1:0]  RST_TIER  = 2'h3;
   localparam logic [3:0]  RST_MASKS = 4'hF;
   localparam logic [3:0]  RST_FLAGS = 4'h0;
   localparam logic        WIDTH_64  = 1'b0;

endpackage : asr_pkg

// ### verif/asr_state_file_tb.sv
// Self-checking bench for the architectural register state file.
// Assumes asr_pkg and asr_state_file are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin compares++; \
   if ((sn) !== (ex)) begin num_errors++; \
   $display("Error %s expected %h seen %h", nm, ex, sn); end end

module asr_state_file_tb;
   // =========================================================
   // Signals
   logic        clk = 1'b0, nrst = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, proc_state;
   logic        pready, pslverr, return_from_handler_valid, undef_fault;
   logic [4:0]  rd_a_idx = 5'h00, rd_b_idx = 5'h00, wr_idx = 5'h00;
   logic        rd_a_wide = 1'b1, rd_b_wide = 1'b0;
   logic        rd_a_sp_ok = 1'b0, rd_b_sp_ok = 1'b0;
   logic [63:0] rd_a_data, rd_b_data, return_from_handler_pc;
   logic        wr_en = 1'b0, wr_wide = 1'b0, wr_sp_ok = 1'b0;
   logic [63:0] wr_data = 64'h0, exc_ret_addr = 64'h0;
   logic        flags_we = 1'b0, ps_we = 1'b0, ps_sel_in = 1'b0;
   logic [3:0]  flags_in = 4'h0, ps_masks_in = 4'h0;
   logic        exc_take = 1'b0, return_from_handler_req = 1'b0;
   logic [1:0]  exc_target = 2'h0, priv_tier;
   logic        stack_sel, step_bit, bad_exec_state_flag;
   logic        exec_width_sel;
   logic [3:0]  cond_flags, mask_bits;
   logic [63:0] w, n;
   logic [31:0] r;
   logic        e;
   int          num_errors = 0;
   int          compares = 0;

   // =========================================================
   // Design
   asr_state_file #(.AW(12)) uut (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rd_a_idx(rd_a_idx), .rd_a_wide(rd_a_wide),
      .rd_a_sp_ok(rd_a_sp_ok), .rd_a_data(rd_a_data),
      .rd_b_idx(rd_b_idx), .rd_b_wide(rd_b_wide),
      .rd_b_sp_ok(rd_b_sp_ok), .rd_b_data(rd_b_data),
      .wr_en(wr_en), .wr_idx(wr_idx), .wr_wide(wr_wide),
      .wr_sp_ok(wr_sp_ok), .wr_data(wr_data),
      .flags_we(flags_we), .flags_in(flags_in), .ps_we(ps_we),
      .ps_masks_in(ps_masks_in), .ps_sel_in(ps_sel_in),
      .exc_take(exc_take), .exc_target(exc_target),
      .exc_ret_addr(exc_ret_addr), .return_from_handler_req(return_from_handler_req),
      .return_from_handler_valid(return_from_handler_valid), .return_from_handler_pc(return_from_handler_pc),
      .undef_fault(undef_fault), .priv_tier(priv_tier),
      .stack_sel(stack_sel), .cond_flags(cond_flags),
      .mask_bits(mask_bits), .step_bit(step_bit),
      .bad_exec_state_flag(bad_exec_state_flag),
      .exec_width_sel(exec_width_sel), .proc_state(proc_state)
   );

   always #5 clk = ~clk;

   // =========================================================
   // Bus and port tasks
   task apb(input logic wt, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rv, output logic ev_err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wt;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rv = prdata;
      ev_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [4:0] i, input logic sp,
           output logic [63:0] wv, output logic [63:0] nv);
      @(posedge clk);
      rd_a_idx <= i;
      rd_b_idx <= i;
      rd_a_sp_ok <= sp;
      rd_b_sp_ok <= sp;
      @(posedge clk);
      #1;
      wv = rd_a_data;
      nv = rd_b_data;
   endtask : rd

   task wr(input logic [4:0] i, input logic wd, input logic sp,
           input logic [63:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_idx <= i;
      wr_wide <= wd;
      wr_sp_ok <= sp;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   // Kind 0 entry, 1 return, 2 flag write, 3 field write
   task ev(input logic [1:0] kd, input logic [1:0] tg,
           input logic [63:0] ra, input logic [4:0] v);
      @(posedge clk);
      exc_take <= (kd == 2'h0);
      return_from_handler_req <= (kd == 2'h1);
      flags_we <= (kd == 2'h2);
      ps_we <= (kd == 2'h3);
      exc_target <= tg;
      exc_ret_addr <= ra;
      flags_in <= v[3:0];
      ps_masks_in <= v[3:0];
      ps_sel_in <= v[4];
      @(posedge clk);
      exc_take <= 1'b0;
      return_from_handler_req <= 1'b0;
      flags_we <= 1'b0;
      ps_we <= 1'b0;
      #1;
   endtask : ev

   // =========================================================
   // Scenarios
   task t_reset;
      #1;
      `CHK("proc_state", 32'h000003CD, proc_state)
      apb(1'b0, asr_pkg::OFS_PS, 32'h0, r, e);
      `CHK("ps read", 32'h000003CD, r)
      apb(1'b0, asr_pkg::OFS_SS1, 32'h0, r, e);
      `CHK("bank1", 32'h0, r)
      `CHK("bank1 err", 1'b0, e)
   endtask : t_reset

   task t_gp;
      wr(5'h03, 1'b1, 1'b0, 64'hFEDCBA9876543210);
      rd(5'h03, 1'b0, w, n);
      `CHK("x3 wide", 64'hFEDCBA9876543210, w)
      `CHK("x3 narrow", 64'h0000000076543210, n)
      wr(5'h1E, 1'b0, 1'b0, 64'h11111111AAAAAAAA);
      rd(5'h1E, 1'b0, w, n);
      `CHK("x30 narrow wr", 64'h00000000AAAAAAAA, w)
      wr(5'h00, 1'b0, 1'b0, 64'h5555555512345678);
      @(posedge clk);
      rd_a_wide <= 1'b0;
      rd_b_wide <= 1'b1;
      rd(5'h00, 1'b0, w, n);
      `CHK("x0 narrow wr", 64'h0000000012345678, n)
      `CHK("x0 port a narrow", 64'h0000000012345678, w)
      @(posedge clk);
      rd_a_wide <= 1'b1;
      rd_b_wide <= 1'b0;
      wr(5'h1F, 1'b1, 1'b0, 64'h0000000000000123);
      rd(5'h1F, 1'b1, w, n);
      `CHK("sp untouched", 64'h0, w)
      wr(5'h1F, 1'b1, 1'b1, 64'h0000000000003000);
      rd(5'h1F, 1'b1, w, n);
      `CHK("sp3", 64'h0000000000003000, w)
      `CHK("sp3 narrow", 64'h0000000000003000, n)
      rd(5'h1F, 1'b0, w, n);
      `CHK("zero wide", 64'h0, w)
      `CHK("zero narrow", 64'h0, n)
   endtask : t_gp

   task t_stack;
      ev(2'h3, 2'h0, 64'h0, 5'h0F);
      `CHK("sel", 1'b0, stack_sel)
      rd(5'h1F, 1'b1, w, n);
      `CHK("sp0", 64'h0, w)
      wr(5'h1F, 1'b1, 1'b1, 64'h0000000000005000);
      ev(2'h3, 2'h0, 64'h0, 5'h1F);
      rd(5'h1F, 1'b1, w, n);
      `CHK("sp3 kept", 64'h0000000000003000, w)
   endtask : t_stack

   task t_entry;
      ev(2'h0, 2'h3, 64'h0000000000001000, 5'h00);
      `CHK("sel entry3", 1'b1, stack_sel)
      apb(1'b0, asr_pkg::OFS_SS3, 32'h0, r, e);
      `CHK("bank3 saved", 32'h000003CD, r)
      `CHK("width saved", 1'b0, r[4])
      apb(1'b1, asr_pkg::OFS_SS3, 32'hA0200014, r, e);
      ev(2'h1, 2'h0, 64'h0, 5'h00);
      `CHK("return_from_handler valid", 1'b1, return_from_handler_valid)
      `CHK("return_from_handler pc", 64'h0000000000001000, return_from_handler_pc)
      `CHK("tier", 2'h1, priv_tier)
      `CHK("flags", 4'hA, cond_flags)
      `CHK("shared sel", 1'b0, stack_sel)
      `CHK("step t1", 1'b1, step_bit)
      `CHK("width t1", 1'b1, exec_width_sel)
      rd(5'h1F, 1'b1, w, n);
      `CHK("sp0 at t1", 64'h0000000000005000, w)
      ev(2'h0, 2'h2, 64'h0000000000002000, 5'h00);
      `CHK("tier2", 2'h2, priv_tier)
      `CHK("masks", 4'hF, mask_bits)
      rd(5'h1F, 1'b1, w, n);
      `CHK("sp2", 64'h0, w)
      apb(1'b0, asr_pkg::OFS_SS2, 32'h0, r, e);
      `CHK("bank2 saved", 32'hA0200014, r)
      apb(1'b0, asr_pkg::OFS_SS3, 32'h0, r, e);
      `CHK("bank3 kept", 32'hA0200014, r)
      apb(1'b1, asr_pkg::OFS_SS3, 32'h0, r, e);
      `CHK("bank3 locked", 1'b1, e)
      apb(1'b1, asr_pkg::OFS_SS2, 32'h0000000C, r, e);
      ev(2'h1, 2'h0, 64'h0, 5'h00);
      `CHK("bad return", 1'b1, bad_exec_state_flag)
      `CHK("bad no branch", 1'b0, return_from_handler_valid)
      apb(1'b1, asr_pkg::OFS_SS2, 32'h50000000, r, e);
      ev(2'h1, 2'h0, 64'h0, 5'h00);
      `CHK("return_from_handler pc2", 64'h0000000000002000, return_from_handler_pc)
      `CHK("state t0", 32'h50000000, proc_state)
   endtask : t_entry

   task t_tier0;
      ev(2'h3, 2'h0, 64'h0, 5'h1F);
      `CHK("undef field", 1'b1, undef_fault)
      `CHK("sel held", 1'b0, stack_sel)
      ev(2'h2, 2'h0, 64'h0, 5'h0C);
      `CHK("flags t0", 4'hC, cond_flags)
      ev(2'h1, 2'h0, 64'h0, 5'h00);
      `CHK("undef return_from_handler", 1'b1, undef_fault)
      `CHK("no return_from_handler", 1'b0, return_from_handler_valid)
      rd(5'h1F, 1'b1, w, n);
      `CHK("sp0 at t0", 64'h0000000000005000, w)
      apb(1'b0, 12'h010, 32'h0, r, e);
      `CHK("unmapped", 1'b1, e)
      apb(1'b1, asr_pkg::OFS_PS, 32'h0, r, e);
      `CHK("ps ro", 1'b1, e)
   endtask : t_tier0

   // =========================================================
   // Main sequence and verdict
   task close_out;
      $display("Checks %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_gp;
      t_stack;
      t_entry;
      t_tier0;
      close_out;
   end

   initial begin
      #100000;
      num_errors++;
      close_out;
   end
endmodule : asr_state_file_tb
`default_nettype wire
